// ==== status_indicator.sv ====
/*
  Status indicator controller: source select, blink, stretch, override
  and polarity for three indicator outputs, with an APB register slave.
  Assumes all inputs are synchronous to core_clk; event inputs are
  one-cycle pulses, levels are held by the line logic.
*/
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
module status_indicator #(
  parameter int MS_COUNT = indicator_pkg::MS_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        link_up,
  input  wire logic        tx_activity,
  input  wire logic        rx_activity,
  input  wire logic        role_master,
  input  wire logic        pseudo_random_test_sequence_err,
  input  wire logic        mac_side_interface_err,
  input  wire logic        basic_status_read,
  input  wire logic        clk_out_as_led2,
  input  wire logic [2:0]  led_strap,
  output logic [2:0]       led_out,
  output logic [2:0]       ext_ctrl_sel
);

  indicator_pkg::ind_state_t st_q;
  indicator_pkg::ind_state_t st_d;

  // -------------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------------
  function automatic logic [11:0] word_index(input logic [15:0] a);
    word_index = a[13:2];
  endfunction

  function automatic logic [7:0] half_period(input logic [1:0] rate);
    case (rate)
      2'h0:    half_period = indicator_pkg::HALF_MS_0;
      2'h1:    half_period = indicator_pkg::HALF_MS_1;
      2'h2:    half_period = indicator_pkg::HALF_MS_2;
      default: half_period = indicator_pkg::HALF_MS_3;
    endcase
  endfunction

  // one entry of the shared source table, active-high level
  function automatic logic source_level(
    input logic [3:0] code,
    input logic       link,
    input logic       ph,
    input logic       tx_a,
    input logic       rx_a,
    input logic       master,
    input logic       lost,
    input logic       tgl,
    input logic       err_a
  );
    case (code)
      indicator_pkg::SRC_LINK:     source_level = link;
      indicator_pkg::SRC_LINK_ACT: source_level = link & ~((tx_a | rx_a) & ph);
      indicator_pkg::SRC_LINK_TX:  source_level = link & ~(tx_a & ph);
      indicator_pkg::SRC_LINK_RX:  source_level = link & ~(rx_a & ph);
      indicator_pkg::SRC_MASTER:   source_level = link & master;
      indicator_pkg::SRC_SLAVE:    source_level = link & ~master;
      indicator_pkg::SRC_ACT:      source_level = tx_a | rx_a;
      indicator_pkg::SRC_LOST:     source_level = lost;
      indicator_pkg::SRC_TEST_ERR: source_level = tgl;
      indicator_pkg::SRC_MAC_ERR:  source_level = err_a;
      default:                     source_level = 1'b0;
    endcase
  endfunction

  // -------------------------------------------------------------------
  // next state
  // -------------------------------------------------------------------
  logic        setup_cyc;
  logic        access_done;
  logic [11:0] idx;
  logic        hit_one;
  logic        hit_two;
  logic        hit_stat;
  logic        ms_tick;
  logic        phase_flip;
  logic        bypass;
  logic        tx_a;
  logic        rx_a;
  logic        err_a;
  logic [3:0]  code;
  logic        lvl;
  logic        drv_en;
  logic        drv_val;
  logic        pol;

  always_comb
  begin
    st_d        = st_q;
    setup_cyc   = psel & ~penable;
    access_done = psel & penable & st_q.pready;
    idx         = word_index(paddr);
    hit_one     = (idx == indicator_pkg::CFG_ONE_INDEX);
    hit_two     = (idx == indicator_pkg::CFG_TWO_INDEX);
    hit_stat    = (idx == indicator_pkg::STATUS_INDEX);
    ms_tick     = (st_q.ms_cnt == 17'(MS_COUNT - 1));
    phase_flip  = ms_tick & (st_q.blink_cnt == 8'h00);
    bypass      = st_q.cfg_one[indicator_pkg::BYPASS_BIT];
    tx_a        = bypass ? tx_activity : (st_q.tx_str | tx_activity);
    rx_a        = bypass ? rx_activity : (st_q.rx_str | rx_activity);
    err_a       = bypass ? mac_side_interface_err
                         : (st_q.err_str | mac_side_interface_err);
    code        = 4'h0;
    lvl         = 1'b0;
    drv_en      = 1'b0;
    drv_val     = 1'b0;
    pol         = 1'b0;

    // polarity taken from inverted straps once after reset release
    if (!st_q.strap_done)
    begin
      st_d.strap_done = 1'b1;
      st_d.cfg_two[0] = ~led_strap[0];
      st_d.cfg_two[3] = ~led_strap[1];
      st_d.cfg_two[6] = ~led_strap[2];
    end

    // ms prescaler and blink phase
    st_d.ms_cnt = ms_tick ? 17'h00000 : st_q.ms_cnt + 17'h00001;
    if (ms_tick)
    begin
      if (phase_flip)
      begin
        st_d.blink_cnt = half_period(
          st_q.cfg_one[indicator_pkg::RATE_LSB +: 2]) - 8'h01;
        st_d.phase     = ~st_q.phase;
      end
      else
      begin
        st_d.blink_cnt = st_q.blink_cnt - 8'h01;
      end
    end

    // stretch: hold an event until the next phase flip, new event wins
    // tx, rx and mac error stretching
    st_d.tx_str  = tx_activity | (st_q.tx_str & ~phase_flip);
    st_d.rx_str  = rx_activity | (st_q.rx_str & ~phase_flip);
    st_d.err_str = mac_side_interface_err | (st_q.err_str & ~phase_flip);

    // link-loss latch, set beats read clear
    st_d.link_prev = link_up;
    if (st_q.link_prev & ~link_up)
      st_d.lost = 1'b1;
    else if (basic_status_read)
      st_d.lost = 1'b0;

    if (pseudo_random_test_sequence_err)
      st_d.test_tgl = ~st_q.test_tgl;

    for (int i = 0; i < 3; i++)
    begin
      code    = st_q.cfg_one[i*indicator_pkg::SRC_WIDTH +: 4];
      lvl     = source_level(code, link_up, st_q.phase, tx_a, rx_a,
                             role_master, st_q.lost, st_q.test_tgl, err_a);
      drv_en  = st_q.cfg_two[i*indicator_pkg::LED_FIELD + 2];
      drv_val = st_q.cfg_two[i*indicator_pkg::LED_FIELD + 1];
      pol     = st_q.cfg_two[i*indicator_pkg::LED_FIELD];
      if (drv_en)
        lvl = drv_val;
      st_d.led[i] = pol ? lvl : ~lvl;
    end
    // indicator 2 only on repurposed clock pin
    if (!clk_out_as_led2)
      st_d.led[2] = 1'b0;

    st_d.ext_sel = st_q.cfg_two[indicator_pkg::EXT_LSB +: 3];

    // apb slave: answer one cycle after setup, zero wait states
    st_d.pready = setup_cyc;
    if (setup_cyc)
    begin
      st_d.pslverr = ~(hit_one | hit_two | hit_stat);
      st_d.prdata  = 32'h00000000;
      if (!pwrite)
      begin
        if (hit_one)
          st_d.prdata = {16'h0000, st_q.cfg_one};
        else if (hit_two)
          st_d.prdata = {16'h0000, st_q.cfg_two};
        else if (hit_stat)
          st_d.prdata = {24'h000000, st_q.phase, st_q.test_tgl,
                         st_q.lost, link_up, st_q.ext_sel[0], st_q.led};
      end
    end
    else if (access_done)
    begin
      st_d.pslverr = 1'b0;
    end
    if (access_done && pwrite && hit_one)
    begin
      st_d.cfg_one = pwdata[15:0] & indicator_pkg::CFG_ONE_MASK;
    end
    if (access_done && pwrite && hit_two)
      st_d.cfg_two = pwdata[15:0] & indicator_pkg::CFG_TWO_MASK;
  end

  // -------------------------------------------------------------------
  // state register
  // -------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_q         <= '0;
      st_q.cfg_one <= indicator_pkg::CFG_ONE_RESET;
      st_q.cfg_two <= indicator_pkg::CFG_TWO_RESET;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign pready       = st_q.pready;
  assign prdata       = st_q.prdata;
  assign pslverr      = st_q.pslverr;
  assign led_out      = st_q.led;
  assign ext_ctrl_sel = st_q.ext_sel;

  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sequence bus_setup_s;
    psel && !penable;
  endsequence

  sequence bus_answer_s;
    st_q.pready && penable;
  endsequence

  // no activity one cycle later, indicator 0 on bypassed activity code
  sequence bypass_quiet_s;
    bypass && st_q.cfg_one[3:0] == indicator_pkg::SRC_ACT
      && !st_q.cfg_two[2] && st_q.cfg_two[0]
      && !tx_activity && !rx_activity;
  endsequence

  cfg_one_reset_a: assert property (
    !st_q.strap_done |-> st_q.cfg_one == indicator_pkg::CFG_ONE_RESET)
    else $error("first register reset value wrong");

  strap_load_a: assert property (
    $rose(st_q.strap_done) |-> st_q.cfg_two[0] == !$past(led_strap[0])
      && st_q.cfg_two[3] == !$past(led_strap[1]))
    else $error("polarity not loaded from inverted strap");

  // output follows the register value of the cycle before, writes included
  override_drive_a: assert property (
    st_q.cfg_two[2] |=>
      led_out[0] == ($past(st_q.cfg_two[1]) ~^ $past(st_q.cfg_two[0])))
    else $error("override value not driven on indicator 0");

  lost_set_a: assert property (
    st_q.link_prev && !link_up |=> st_q.lost)
    else $error("link loss not latched");

  lost_hold_a: assert property (
    st_q.lost && !basic_status_read |=> st_q.lost)
    else $error("link loss cleared without status read");

  test_toggle_a: assert property (
    pseudo_random_test_sequence_err |=> st_q.test_tgl != $past(st_q.test_tgl))
    else $error("error toggle missed");

  bus_answer_a: assert property (
    bus_setup_s |=> bus_answer_s)
    else $error("apb answer not one cycle after setup");

  led_two_off_a: assert property (
    !clk_out_as_led2 |=> led_out[2] == 1'b0)
    else $error("indicator 2 driven while absent");

  reserved_dark_a: assert property (
    st_q.cfg_one[3:0] == 4'h7 && !st_q.cfg_two[2]
      |=> led_out[0] == !$past(st_q.cfg_two[0]))
    else $error("reserved source not inactive");

  bypass_live_a: assert property (
    (tx_activity || rx_activity) ##1 bypass_quiet_s |=> led_out[0] == 1'b0)
    else $error("activity stretched while bypassed");

endmodule // status_indicator

// ==== indicator_pkg.sv ====
/*
  Constants and carriers of the status indicator block.
  Assumes one 100 MHz core clock and word-aligned APB access.
*/
package indicator_pkg;

  // -------------------------------------------------------------------
  // register map (printed offsets are indices; byte address is 4x)
  // -------------------------------------------------------------------
  localparam logic [11:0] CFG_ONE_INDEX  = 12'h450;
  localparam logic [11:0] CFG_TWO_INDEX  = 12'h451;
  localparam logic [11:0] STATUS_INDEX   = 12'h460;
  localparam logic [15:0] CFG_ONE_RESET  = 16'h2610;
  localparam logic [15:0] CFG_TWO_RESET  = 16'h0049;
  localparam logic [15:0] CFG_ONE_MASK   = 16'h7FFF;
  localparam logic [15:0] CFG_TWO_MASK   = 16'hE1FF;

  // -------------------------------------------------------------------
  // field positions
  // -------------------------------------------------------------------
  localparam int BYPASS_BIT  = 14;
  localparam int RATE_LSB    = 12;
  localparam int SRC_WIDTH   = 4;
  localparam int EXT_LSB     = 13;
  localparam int LED_FIELD   = 3;

  // -------------------------------------------------------------------
  // source codes
  // -------------------------------------------------------------------
  localparam logic [3:0] SRC_LINK      = 4'h0;
  localparam logic [3:0] SRC_LINK_ACT  = 4'h1;
  localparam logic [3:0] SRC_LINK_TX   = 4'h2;
  localparam logic [3:0] SRC_LINK_RX   = 4'h3;
  localparam logic [3:0] SRC_MASTER    = 4'h4;
  localparam logic [3:0] SRC_SLAVE     = 4'h5;
  localparam logic [3:0] SRC_ACT       = 4'h6;
  localparam logic [3:0] SRC_LOST      = 4'h9;
  localparam logic [3:0] SRC_TEST_ERR  = 4'hA;
  localparam logic [3:0] SRC_MAC_ERR   = 4'hB;

  // -------------------------------------------------------------------
  // timing
  // -------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS         = 1000000;
  localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
  // half blink periods in ms for rate codes 0..3
  localparam logic [7:0] HALF_MS_0 = 8'h19;
  localparam logic [7:0] HALF_MS_1 = 8'h32;
  localparam logic [7:0] HALF_MS_2 = 8'h64;
  localparam logic [7:0] HALF_MS_3 = 8'hFA;

  typedef struct packed {
    logic [15:0] cfg_one;
    logic [15:0] cfg_two;
    logic        strap_done;
    logic [16:0] ms_cnt;
    logic [7:0]  blink_cnt;
    logic        phase;
    logic        tx_str;
    logic        rx_str;
    logic        err_str;
    logic        link_prev;
    logic        lost;
    logic        test_tgl;
    logic [2:0]  led;
    logic [2:0]  ext_sel;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } ind_state_t;

endpackage

// ==== indicator_leds.sv ====
/*
  Board-side indicator lamps and the strap resistors on their pins.
  Assumes led_level comes straight from the indicator outputs.
*/
`timescale 1ns/1ps
module indicator_leds #(
  parameter logic [2:0] STRAP = 3'h2
) (
  input  wire logic [2:0] led_level,
  output logic      [2:0] led_strap,
  output logic      [2:0] lit
);
  // strap sets wiring
  // a strap pulled low means the lamp hangs to ground: lit on high level
  assign led_strap = STRAP;
  assign lit       = led_level ^ STRAP;
endmodule // indicator_leds

// ==== status_indicator_tb.sv ====
/*
  Self-checking bench of the status indicator with its lamp model.
  Assumes MS_COUNT of 4 and an APB slave that answers with pready.
*/
`timescale 1ns/1ps
module status_indicator_tb;
  localparam int         MSC   = 4;
  localparam logic [2:0] STRAP = 3'h2;
  typedef struct packed {
    logic [3:0] code;
    logic       link, master, tx, rx, pol, en, val, exp;
  } row_t;
  logic        core_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic        link_up, tx_activity, rx_activity, role_master, seq_err;
  logic        mac_err, basic_status_read, clk_out_as_led2, err, s;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  led_strap, led_out, ext_ctrl_sel, lit;
  row_t        rows [19];
  row_t        r;
  int          miscompares, n_compared, cycles, c;
  int          per_ms [4] = '{50, 100, 200, 500};

  status_indicator #(.MS_COUNT(MSC)) i_status_indicator (
    .core_clk(core_clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .link_up(link_up), .tx_activity(tx_activity),
    .rx_activity(rx_activity), .role_master(role_master),
    .pseudo_random_test_sequence_err(seq_err),
    .mac_side_interface_err(mac_err),
    .basic_status_read(basic_status_read),
    .clk_out_as_led2(clk_out_as_led2), .led_strap(led_strap),
    .led_out(led_out), .ext_ctrl_sel(ext_ctrl_sel));
  indicator_leds #(.STRAP(STRAP)) i_indicator_leds (
    .led_level(led_out), .led_strap(led_strap), .lit(lit));

  always #5 core_clk = ~core_clk;

  // --------------------------------------------------------------------
  // bus cycles and comparisons
  // --------------------------------------------------------------------
  task automatic apb(input logic wr, input logic [11:0] idx,
                     input logic [15:0] wd);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= wr;
    paddr   <= {2'h0, idx, 2'h0};
    pwdata  <= {16'h0000, wd};
    @(posedge core_clk);
    penable <= 1'h1;
    // pready high ends this wait; the bench timeout ends it if pready never comes
    do
      @(posedge core_clk);
    while (pready !== 1'h1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge core_clk);
  endtask

  task automatic cfg(input logic [15:0] one, input logic [15:0] two);
    apb(1'h1, indicator_pkg::CFG_ONE_INDEX, one);
    apb(1'h1, indicator_pkg::CFG_TWO_INDEX, two);
  endtask

  task automatic chk_word(input string what, input logic [31:0] exp,
                          input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_led(input string what, input logic [2:0] exp,
                         input logic [2:0] got);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic settle;
    repeat (3) @(posedge core_clk);
  endtask

  // waits for a change of one indicator, counting cycles up to lim
  task automatic wait_flip(input int i, input int lim, output int n);
    logic v;
    v = led_out[i];
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (led_out[i] === v && n < lim);
  endtask

  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // a hang counts as a mismatch
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      miscompares++;
      conclude();
    end
  end

  // --------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------
  initial
  begin
    // code, then link master tx rx pol en val expected level
    rows = '{12'h089, 12'h008, 12'h080, 12'h001, 12'h4C9, 12'h488,
             12'h589, 12'h5C8, 12'h299, 12'h3A9, 12'h788, 12'h8C8,
             12'hF88, 12'h00F, 12'h08C, 12'h086, 12'h781, 12'h688,
             12'h189};
    core_clk = 1'h0; sys_rst = 1'h1; psel = 1'h0; penable = 1'h0;
    pwrite = 1'h0; paddr = 16'h0000; pwdata = 32'h00000000;
    link_up = 1'h1; tx_activity = 1'h0; rx_activity = 1'h0;
    role_master = 1'h0; seq_err = 1'h0; mac_err = 1'h0;
    basic_status_read = 1'h0; clk_out_as_led2 = 1'h0;
    miscompares = 0; n_compared = 0; cycles = 0;
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'h0;
    settle();
    apb(1'h0, indicator_pkg::CFG_ONE_INDEX, 16'h0000);
    chk_word("cfg one reset", 32'h00002610, rd);
    apb(1'h0, indicator_pkg::CFG_TWO_INDEX, 16'h0000);
    chk_word("cfg two reset", {25'h0, ~STRAP[2], 2'h0, ~STRAP[1], 2'h0,
             ~STRAP[0]}, rd);
    chk_led("lamps lit", 3'h3, lit);
    $display("test reset done");
    for (int i = 0; i < 19; i++)
    begin
      r = rows[i];
      // bypass keeps stretched activity of earlier rows out of the table
      cfg({12'h400, r.code}, {13'h0000, r.en, r.val, r.pol});
      link_up     <= r.link;
      role_master <= r.master;
      tx_activity <= r.tx;
      rx_activity <= r.rx;
      settle();
      chk_led("row", {2'h0, r.exp}, {2'h0, led_out[0]});
    end
    $display("test source table done"); // covered above
    for (int k = 0; k < 4; k++)
    begin
      cfg({2'h0, k[1:0], 4'h0, 4'h0, (k == 0) ? 4'h2 :
          (k == 1) ? 4'h3 : 4'h1}, 16'h0009);
      link_up     <= 1'h1;
      tx_activity <= (k == 0 || k == 3);
      rx_activity <= (k == 1 || k == 2);
      wait_flip(0, 3000, c);
      wait_flip(0, 3000, c);
      wait_flip(0, 3000, c);
      chk_word("half blink", per_ms[k] / 2 * MSC, c);
    end
    $display("test blink done");
    tx_activity <= 1'h0;
    rx_activity <= 1'h1;
    for (int b = 1; b >= 0; b--)
    begin
      cfg({1'h0, b[0], 2'h0, 4'h0, 4'h3, 4'hB}, 16'h0009);
      wait_flip(1, 3000, c);
      mac_err <= 1'h1;
      @(posedge core_clk);
      mac_err <= 1'h0;
      @(posedge core_clk);
      chk_led("error shown", 3'h1, {2'h0, led_out[0]});
      @(posedge core_clk);
      chk_led("stretch", {2'h0, ~b[0]}, {2'h0, led_out[0]});
      wait_flip(0, 2 * per_ms[0] / 2 * MSC + 10, c);
      chk_led("stretch end", 3'h0, {2'h0, led_out[0]});
    end
    cfg(16'h4006, 16'h0009);
    tx_activity <= 1'h1;
    rx_activity <= 1'h0;
    @(posedge core_clk);
    tx_activity <= 1'h0;
    @(posedge core_clk);
    chk_led("bypass on", 3'h1, {2'h0, led_out[0]});
    @(posedge core_clk);
    chk_led("bypass off", 3'h0, {2'h0, led_out[0]});
    $display("test stretch done");
    cfg(16'h0009, 16'h0009);
    basic_status_read <= 1'h1;
    @(posedge core_clk);
    basic_status_read <= 1'h0;
    settle();
    chk_led("lost idle", 3'h0, {2'h0, led_out[0]});
    link_up <= 1'h0;
    settle();
    link_up <= 1'h1;
    settle();
    chk_led("lost held", 3'h1, {2'h0, led_out[0]});
    basic_status_read <= 1'h1;
    @(posedge core_clk);
    basic_status_read <= 1'h0;
    settle();
    chk_led("lost clear", 3'h0, {2'h0, led_out[0]});
    cfg(16'h000A, 16'h0009);
    s = led_out[0];
    repeat (2)
    begin
      seq_err <= 1'h1;
      @(posedge core_clk);
      seq_err <= 1'h0;
      settle();
      s = ~s;
      chk_led("toggle", {2'h0, s}, {2'h0, led_out[0]});
    end
    $display("test latch and toggle done");
    cfg(16'h0007, 16'hE049);
    clk_out_as_led2 <= 1'h1;
    settle();
    chk_led("fields", 3'h6, led_out);
    chk_word("ext select", 32'h7, {29'h0, ext_ctrl_sel});
    clk_out_as_led2 <= 1'h0;
    settle();
    chk_led("no third", 3'h2, led_out);
    cfg(16'hFFFF, 16'hFFFF);
    apb(1'h0, indicator_pkg::CFG_ONE_INDEX, 16'h0000);
    chk_word("cfg one bits", 32'h00007FFF, rd);
    apb(1'h0, indicator_pkg::CFG_TWO_INDEX, 16'h0000);
    chk_word("cfg two bits", 32'h0000E1FF, rd);
    apb(1'h0, 12'h452, 16'h0000);
    chk_word("unmapped", 32'h00000001, {rd[30:0], err});
    sys_rst <= 1'h1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'h0;
    settle();
    apb(1'h0, indicator_pkg::CFG_ONE_INDEX, 16'h0000);
    chk_word("cfg one again", 32'h00002610, rd);
    apb(1'h0, indicator_pkg::STATUS_INDEX, 16'h0000);
    chk_word("status", 32'h00000011, rd & 32'hFFFFFF7F);
    $display("test registers done");
    conclude();
  end
endmodule // status_indicator_tb
